/* File: verilog/icsc_pkg.sv */
// Constants, types and register map of the interrupt status and configuration block
// What this block does
// R1: Enable state of 32-38 readable
// R2: Pending bits 31-16, 14, 12 readable
// R3: Pending 2,3 readable; bits 1,0 zero
// R4: Pending state of 32-38 readable
// R5: Priority below threshold is withheld
// R6: Zero threshold disables masking
// R7: Only threshold bits 7:6 stored
// R8: Protected bit needs key; key reads zero
// R9: Three sixteen bit unlock keys; only THIRD_UNLOCK_KEY (16'hbeef) is checked, the other two are unused
// R10: Keyed write requests self-clearing system reset
// R11: Any-pending flag in global status
// R12: Any-active flag in global status
// R13: Nesting field 01/03, two levels max
// R14: Fast channel numbers read-write
// R15: Handler address bits 31:1, bit0 zero
// R16: Bit 0 enables fast channel
// R17: Enable-set write 1 enables, write-only
// R18: Interrupts 2,3 always enabled
// R19: Enable writes ignored for 2,3
// R20: Enable state reflects writes immediately
// R21: Pending set by source, cleared on accept
package icsc_pkg;
   // ***************************************
   // Register byte offsets
   // ***************************************
   localparam logic [11:0] ADDR_EN_STATE_LOW = 12'h000;
   localparam logic [11:0] ADDR_EN_STATE_HIGH = 12'h004;
   localparam logic [11:0] ADDR_PEND_STATE_LOW = 12'h020;
   localparam logic [11:0] ADDR_PEND_STATE_HIGH = 12'h024;
   localparam logic [11:0] ADDR_PRIO_THRESHOLD = 12'h040;
   localparam logic [11:0] ADDR_KEYED_CONFIG = 12'h048;
   localparam logic [11:0] ADDR_GLOBAL_STATUS = 12'h04c;
   localparam logic [11:0] ADDR_FAST_IDS = 12'h050;
   localparam logic [11:0] ADDR_FAST0_ADDRESS = 12'h060;
   localparam logic [11:0] ADDR_FAST1_ADDRESS = 12'h064;
   localparam logic [11:0] ADDR_EN_SET_LOW = 12'h100;
   localparam logic [11:0] ADDR_EN_SET_HIGH = 12'h104;
   // ***************************************
   // Interrupt numbering and fields
   // ***************************************
   localparam int NUM_IRQ = 39;
   localparam int HIGH_BASE = 32;
   localparam int HIGH_W = 7;
   localparam logic [38:0] IRQ_VALID = 39'h7f_ffff_500c;
   localparam logic [38:0] IRQ_FIXED_EN = 39'h00_0000_000c;
   localparam logic [38:0] IRQ_SETTABLE = IRQ_VALID & ~IRQ_FIXED_EN;
   localparam logic [15:0] FIRST_UNLOCK_KEY = 16'hfa05;
   localparam logic [15:0] SECOND_UNLOCK_KEY = 16'hbcaf;
   localparam logic [15:0] THIRD_UNLOCK_KEY = 16'hbeef;
   localparam int KEY_LSB = 16;
   localparam int SYSRST_BIT = 7;
   localparam int THR_LSB = 6;
   localparam int GPEND_BIT = 9;
   localparam int GACT_BIT = 8;
   localparam int FID1_LSB = 8;
   localparam logic [7:0] NEST_CODE_ONE = 8'h01;
   localparam logic [7:0] NEST_CODE_TWO = 8'h03;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   // Nesting depth, one-hot
   typedef enum logic [2:0] {
      NEST_IDLE = 3'b001,
      NEST_ONE = 3'b010,
      NEST_TWO = 3'b100
   } icsc_nest_e;
   // Whole state of the block
   typedef struct packed {
      icsc_nest_e nest;
      logic [38:0] en;
      logic [38:0] pend;
      logic [1:0] thr;
      logic [7:0] fid0;
      logic [7:0] fid1;
      logic [31:0] fa0;
      logic [31:0] fa1;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic sysrst;
      logic svc_valid;
      logic [5:0] svc_num;
      logic [1:0] svc_fast;
      logic [31:0] svc_addr;
   } icsc_state_s;
endpackage

/* File: verilog/icsc_pick.sv */
// Picks the lowest numbered pending, enabled, unmasked interrupt
`timescale 1ns/100ps
module icsc_pick
   import icsc_pkg::*;
(
   input wire logic [38:0] pend,
   input wire logic [38:0] en,
   input wire logic [77:0] prio,
   input wire logic [1:0] thr,
   output logic hit,
   output logic [5:0] num
);
   // Walk from the top so the lowest number wins
   always_comb begin
      hit = 1'b0;
      num = 6'h00;
      for (int i = NUM_IRQ - 1; i >= 0; i--) begin
         if (pend[i] && en[i] &&
             ((thr == 2'b00) || (prio[2*i +: 2] >= thr))) begin // R5 R6
            hit = 1'b1;
            num = 6'(i);
         end
      end
   end
endmodule

/* File: verilog/icsc_top.sv */
// APB status and configuration block of the interrupt controller
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
module icsc_top
   import icsc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [38:0] irq_req,
   input wire logic [77:0] irq_prio,
   input wire logic core_ack,
   input wire logic core_ret,
   output logic svc_valid,
   output logic [5:0] svc_num,
   output logic [1:0] svc_fast,
   output logic [31:0] svc_addr,
   output logic sys_reset_req
);
   // ***************************************
   // State and helpers
   // ***************************************
   icsc_state_s st_q;
   icsc_state_s st_d;
   logic pick_hit;
   logic [5:0] pick_num;
   logic setup;
   logic wr_acc;
   logic [38:0] ack_clr;
   logic [38:0] pend_next;
   logic [7:0] nest_code;

   // Arbitration over the next pending set
   icsc_pick u_pick (
      .pend(pend_next),
      .en(st_q.en),
      .prio(irq_prio),
      .thr(st_q.thr),
      .hit(pick_hit),
      .num(pick_num)
   );

   // Bus phases: read data prepared in setup, writes land on access
   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite && st_q.ready;

   // Accepted interrupt leaves the pending set
   always_comb begin
      ack_clr = '0;
      if (core_ack && st_q.svc_valid && st_q.nest != NEST_TWO) begin
         ack_clr[st_q.svc_num] = 1'b1;
      end
   end

   // New requests win over a clear in the same cycle
   assign pend_next = ((st_q.pend & ~ack_clr) | irq_req) & IRQ_VALID; // R21

   // Nesting field encoding
   always_comb begin
      case (st_q.nest)
         NEST_ONE: nest_code = NEST_CODE_ONE; // R13
         NEST_TWO: nest_code = NEST_CODE_TWO; // R13
         default: nest_code = 8'h00;
      endcase
   end

   // ***************************************
   // Next state
   // ***************************************
   always_comb begin
      st_d = st_q;
      st_d.pend = pend_next;
      st_d.sysrst = 1'b0; // R10
      st_d.en = st_q.en | IRQ_FIXED_EN; // R18

      // Nesting depth follows accepts and returns
      case (st_q.nest)
         NEST_IDLE: begin
            if (|ack_clr) begin
               st_d.nest = NEST_ONE;
            end
         end
         NEST_ONE: begin
            if (|ack_clr && !core_ret) begin
               st_d.nest = NEST_TWO; // R13
            end else if (core_ret && !(|ack_clr)) begin
               st_d.nest = NEST_IDLE;
            end
         end
         NEST_TWO: begin
            if (core_ret) begin
               st_d.nest = NEST_ONE;
            end
         end
         default: st_d.nest = NEST_IDLE;
      endcase

      // Service offer to the core
      st_d.svc_valid = pick_hit;
      st_d.svc_num = pick_num;
      st_d.svc_fast = 2'b00;
      st_d.svc_addr = ZERO_WORD;
      // No channel match is shown while nothing is offered
      if (pick_hit && st_q.fa0[0] && st_q.fid0 == {2'b00, pick_num}) begin // R16
         st_d.svc_fast = 2'b01;
         st_d.svc_addr = {st_q.fa0[31:1], 1'b0}; // R15
      end else if (pick_hit && st_q.fa1[0] && st_q.fid1 == {2'b00, pick_num}) begin // R16
         st_d.svc_fast = 2'b10;
         st_d.svc_addr = {st_q.fa1[31:1], 1'b0}; // R15
      end

      // Bus answer: ready after one setup cycle
      if (setup) begin
         st_d.ready = 1'b1;
      end else if (psel && penable && st_q.ready) begin
         st_d.ready = 1'b0;
         st_d.slverr = 1'b0; // Error stands only with pready
      end

      // Read data and error for the addressed register
      if (setup) begin
         st_d.rdata = ZERO_WORD;
         st_d.slverr = 1'b0;
         if (paddr == ADDR_EN_STATE_LOW) begin
            st_d.rdata = {st_q.en[31:16], 1'b0, st_q.en[14], 1'b0,
                          st_q.en[12], 8'h00, st_q.en[3:2], 2'b00}; // R20
         end else if (paddr == ADDR_EN_STATE_HIGH) begin
            st_d.rdata[HIGH_W-1:0] = st_q.en[NUM_IRQ-1:HIGH_BASE]; // R1
         end else if (paddr == ADDR_PEND_STATE_LOW) begin
            st_d.rdata = {st_q.pend[31:16], 1'b0, st_q.pend[14], 1'b0,
                          st_q.pend[12], 8'h00, st_q.pend[3:2], 2'b00}; // R2 R3
         end else if (paddr == ADDR_PEND_STATE_HIGH) begin
            st_d.rdata[HIGH_W-1:0] = st_q.pend[NUM_IRQ-1:HIGH_BASE]; // R4
         end else if (paddr == ADDR_PRIO_THRESHOLD) begin
            st_d.rdata[THR_LSB +: 2] = st_q.thr; // R7
         end else if (paddr == ADDR_KEYED_CONFIG) begin
            st_d.rdata = ZERO_WORD; // R8
         end else if (paddr == ADDR_GLOBAL_STATUS) begin
            st_d.rdata[GPEND_BIT] = |st_q.pend; // R11
            st_d.rdata[GACT_BIT] = st_q.nest != NEST_IDLE; // R12
            st_d.rdata[7:0] = nest_code; // R13
         end else if (paddr == ADDR_FAST_IDS) begin
            st_d.rdata[15:0] = {st_q.fid1, st_q.fid0}; // R14
         end else if (paddr == ADDR_FAST0_ADDRESS) begin
            st_d.rdata = st_q.fa0;
         end else if (paddr == ADDR_FAST1_ADDRESS) begin
            st_d.rdata = st_q.fa1;
         end else if (paddr == ADDR_EN_SET_LOW || paddr == ADDR_EN_SET_HIGH) begin
            st_d.rdata = ZERO_WORD; // R17
         end else begin
            st_d.slverr = 1'b1;
         end
      end

      // Register writes on the access edge
      if (wr_acc) begin
         if (paddr == ADDR_PRIO_THRESHOLD) begin
            st_d.thr = pwdata[THR_LSB +: 2]; // R7
         end else if (paddr == ADDR_KEYED_CONFIG) begin
            if (pwdata[SYSRST_BIT] &&
                pwdata[KEY_LSB +: 16] == THIRD_UNLOCK_KEY) begin // R8 R9 R10
               st_d.sysrst = 1'b1;
            end
         end else if (paddr == ADDR_FAST_IDS) begin
            st_d.fid0 = pwdata[7:0]; // R14
            st_d.fid1 = pwdata[FID1_LSB +: 8]; // R14
         end else if (paddr == ADDR_FAST0_ADDRESS) begin
            st_d.fa0 = pwdata; // R15 R16
         end else if (paddr == ADDR_FAST1_ADDRESS) begin
            st_d.fa1 = pwdata; // R15 R16
         end else if (paddr == ADDR_EN_SET_LOW) begin
            st_d.en = st_d.en | (IRQ_SETTABLE & {7'h00, pwdata}); // R17 R19
         end else if (paddr == ADDR_EN_SET_HIGH) begin
            st_d.en[NUM_IRQ-1:HIGH_BASE] =
               st_d.en[NUM_IRQ-1:HIGH_BASE] | pwdata[HIGH_W-1:0];
         end
      end
   end

   // ***************************************
   // State register
   // ***************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '0;
         st_q.nest <= NEST_IDLE;
         st_q.en <= IRQ_FIXED_EN; // R18
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from the state register
   assign prdata = st_q.rdata;
   assign pready = st_q.ready;
   assign pslverr = st_q.slverr;
   assign svc_valid = st_q.svc_valid;
   assign svc_num = st_q.svc_num;
   assign svc_fast = st_q.svc_fast;
   assign svc_addr = st_q.svc_addr;
   assign sys_reset_req = st_q.sysrst;

   // ***************************************
   // Assertions
   // ***************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence seq_cfg_write;
      psel && penable && pwrite && pready && paddr == ADDR_KEYED_CONFIG;
   endsequence

   sequence seq_reset_pulse;
      sys_reset_req ##1 !sys_reset_req;
   endsequence

   a_reset_key_pulse: assert property ( // R10
      seq_cfg_write ##0 (pwdata[SYSRST_BIT] && pwdata[31:16] == 16'hbeef)
      |=> seq_reset_pulse)
      else $error("keyed reset request did not pulse once");

   a_reset_needs_key: assert property ( // R8
      seq_cfg_write ##0 (pwdata[31:16] != 16'hbeef) |=> !sys_reset_req)
      else $error("reset request without the key");

   a_thr_low_zero: assert property ( // R7
      psel && !penable && !pwrite && paddr == ADDR_PRIO_THRESHOLD
      |=> prdata[5:0] == 6'h00 && prdata[31:8] == 24'h0)
      else $error("threshold low bits not zero");

   a_enset_visible: assert property ( // R17
      psel && penable && pwrite && pready && paddr == ADDR_EN_SET_LOW
      && pwdata[16] |=> st_q.en[16])
      else $error("enable set write lost");

   a_fixed_enabled: assert property ( // R18
      st_q.en[3:2] == 2'b11 && st_q.en[1:0] == 2'b00)
      else $error("interrupts 2 and 3 not enabled");

   a_pend_set_wins: assert property ( // R21
      irq_req[16] |=> st_q.pend[16])
      else $error("pending request lost");

   a_gpend_read: assert property ( // R11
      psel && !penable && paddr == ADDR_GLOBAL_STATUS
      |=> prdata[9] == $past(|st_q.pend))
      else $error("any pending flag wrong");

   a_nest_second: assert property ( // R13
      st_q.nest == NEST_ONE && core_ack && svc_valid && !core_ret
      |=> st_q.nest == NEST_TWO ##0 nest_code == 8'h03)
      else $error("second nesting level not shown");

   a_withheld_prio: assert property ( // R5
      svc_valid && $past(st_q.thr) != 2'b00
      |-> 2'($past(irq_prio) >> {svc_num, 1'b0}) >= $past(st_q.thr))
      else $error("service offered below threshold");

   // Accept by the core, counted only below the nesting limit
   sequence seq_accept;
      core_ack && svc_valid && st_q.nest != NEST_TWO;
   endsequence

   a_accept_clears: assert property ( // R21
      seq_accept ##0 !irq_req[svc_num] |=> !st_q.pend[$past(svc_num)])
      else $error("accepted interrupt still pending");

   a_nest_return: assert property ( // R13
      st_q.nest == NEST_TWO && core_ret |=> st_q.nest == NEST_ONE)
      else $error("return from second level lost");

   a_active_read: assert property ( // R12
      psel && !penable && paddr == ADDR_GLOBAL_STATUS
      |=> prdata[8] == $past(st_q.nest != NEST_IDLE))
      else $error("any active flag wrong");

   a_thr_zero_open: assert property ( // R6
      st_q.thr == 2'b00 && |(pend_next & st_q.en) |=> svc_valid)
      else $error("eligible interrupt withheld with zero threshold");
endmodule

/* File: verification/icsc_core_model.sv */
// Behavioural model of the processor core that takes offered interrupts
`timescale 1ns/100ps
module icsc_core_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic svc_valid,
   input wire logic go_ack,
   input wire logic go_ret,
   output logic core_ack,
   output logic core_ret
);
   // Accept only what is offered, one pulse per command; return on command
   always_ff @(posedge clk) begin
      if (rst) begin
         core_ack <= 1'b0;
         core_ret <= 1'b0;
      end else begin
         core_ack <= go_ack & svc_valid & ~core_ack;
         core_ret <= go_ret & ~core_ret;
      end
   end
endmodule

/* File: verification/tb.sv */
// Self-checking testbench of the interrupt status and configuration block
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
   $display("CHECK FAILED %0t got %h exp %h", $time, (a), (e)); end end
module tb;
   import icsc_pkg::*;
   typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e;} icsc_row_s;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, core_ack, core_ret;
   logic go_ack, go_ret, svc_valid, sys_reset_req, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, svc_addr, rd;
   logic [38:0] irq_req;
   logic [77:0] irq_prio;
   logic [5:0] svc_num;
   logic [1:0] svc_fast;
   int n_fail, compares, cyc, n_rst, r0;
   icsc_row_s rows[17] = '{
      '{0, ADDR_EN_STATE_LOW, 0, 32'h0000_000c}, '{0, ADDR_EN_STATE_HIGH, 0, 0},
      '{0, ADDR_PEND_STATE_LOW, 0, 0}, '{0, ADDR_GLOBAL_STATUS, 0, 0},
      '{1, ADDR_PRIO_THRESHOLD, 32'hffff_ffff, 0}, '{0, ADDR_PRIO_THRESHOLD, 0, 32'h0000_00c0},
      '{1, ADDR_FAST_IDS, 32'hffff_abcd, 0}, '{0, ADDR_FAST_IDS, 0, 32'h0000_abcd},
      '{1, ADDR_FAST1_ADDRESS, 32'h8765_4321, 0}, '{0, ADDR_FAST1_ADDRESS, 0, 32'h8765_4321},
      '{1, ADDR_KEYED_CONFIG, 32'hbeef_0000, 0}, '{0, ADDR_KEYED_CONFIG, 0, 0},
      '{1, ADDR_EN_SET_LOW, 32'hffff_ffff, 0}, '{0, ADDR_EN_STATE_LOW, 0, 32'hffff_500c},
      '{1, ADDR_EN_SET_HIGH, 32'h0000_007f, 0}, '{0, ADDR_EN_STATE_HIGH, 0, 32'h0000_007f},
      '{0, 12'h008, 0, 0}};
   icsc_top icsc_top_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq_req(irq_req), .irq_prio(irq_prio), .core_ack(core_ack), .core_ret(core_ret),
      .svc_valid(svc_valid), .svc_num(svc_num), .svc_fast(svc_fast), .svc_addr(svc_addr),
      .sys_reset_req(sys_reset_req));
   icsc_core_model icsc_core_model_i (.clk(clk), .rst(rst), .svc_valid(svc_valid),
      .go_ack(go_ack), .go_ret(go_ret), .core_ack(core_ack), .core_ret(core_ret));
   // Clock and cycle guard
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (sys_reset_req === 1'b1) n_rst++;
      if (cyc == 5000) begin
         n_fail++;
         complete_run();
      end
   end
   // ***************************************
   // Tasks
   // ***************************************
   task automatic complete_run();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the cycle guard ends a wait for pready
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 0);
      `CHK(rd, e)
   endtask
   task automatic cmd(input int k, input logic [38:0] v);
      if (k == 0) irq_req <= v;
      if (k == 1) go_ack <= 1'b1;
      if (k == 2) go_ret <= 1'b1;
      @(posedge clk);
      irq_req <= '0;
      go_ack <= 1'b0;
      go_ret <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   // ***************************************
   // Main sequence
   // ***************************************
   initial begin
      {rst, psel, penable, pwrite, go_ack, go_ret} = 6'b100000;
      {paddr, pwdata, irq_req, irq_prio} = '0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (rows[i]) begin
         if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
         else rd_chk(rows[i].a, rows[i].e);
      end
      `CHK(err, 1'b1)
      $display("register table done");
      irq_prio[33:32] <= 2'b01;
      apb(1'b1, ADDR_FAST_IDS, 32'h0000_0010);
      apb(1'b1, ADDR_FAST0_ADDRESS, 32'h0000_1235);
      cmd(0, 39'h1_0000);
      rd_chk(ADDR_PEND_STATE_LOW, 32'h0001_0000);
      rd_chk(ADDR_GLOBAL_STATUS, 32'h0000_0200);
      `CHK(svc_valid, 1'b0)
      apb(1'b1, ADDR_PRIO_THRESHOLD, 32'h0000_00ff);
      `CHK(svc_valid, 1'b0)
      apb(1'b1, ADDR_PRIO_THRESHOLD, 0);
      @(posedge clk);
      `CHK({svc_valid, svc_num, svc_fast, svc_addr}, {1'b1, 6'd16, 2'b01, 32'h1234})
      cmd(1, 0);
      rd_chk(ADDR_GLOBAL_STATUS, 32'h0000_0101);
      cmd(0, 39'h10_0000);
      cmd(1, 0);
      rd_chk(ADDR_GLOBAL_STATUS, 32'h0000_0103);
      cmd(0, 39'h2_0000_000f);
      cmd(1, 0);
      rd_chk(ADDR_PEND_STATE_LOW, 32'h0000_000c);
      rd_chk(ADDR_PEND_STATE_HIGH, 32'h0000_0002);
      cmd(2, 0);
      cmd(2, 0);
      rd_chk(ADDR_GLOBAL_STATUS, 32'h0000_0200);
      $display("interrupt flow done");
      r0 = n_rst;
      apb(1'b1, ADDR_KEYED_CONFIG, 32'hfa05_0080);
      apb(1'b1, ADDR_KEYED_CONFIG, 32'hbeef_0000);
      repeat (2) @(posedge clk);
      `CHK(n_rst - r0, 0)
      apb(1'b1, ADDR_KEYED_CONFIG, 32'hbeef_0080);
      repeat (2) @(posedge clk);
      `CHK(n_rst - r0, 1)
      $display("keyed reset done");
      // Reset in mid-run brings back the fixed enables only
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_chk(ADDR_EN_STATE_LOW, 32'h0000_000c);
      rd_chk(ADDR_EN_STATE_HIGH, 0);
      rd_chk(ADDR_PRIO_THRESHOLD, 0);
      rd_chk(ADDR_PEND_STATE_HIGH, 0);
      $display("mid-run reset done");
      complete_run();
   end
endmodule
